/* include/ifc_regs.svh */
`ifndef IFC_REGS_SVH
`define IFC_REGS_SVH
`define IFC_WORD_W 24
`define IFC_OPC_W 8
`define IFC_OPC_MSB 23
`define IFC_OPC_LSB 16
`define IFC_OPC_NOP 8'h00
`define IFC_OPC_DW0 8'h02
`define IFC_OPC_DW1 8'h04
`define IFC_OPC_DW2 8'hbe
`define IFC_OPC_BRANCH 8'h37
`define IFC_OPC_CALL_IND 8'h01
`define IFC_OPC_TBL_LO 8'hba
`define IFC_OPC_TBL_HI 8'hbb
`define IFC_OPC_RET 8'h06
`define IFC_OPC_SKIP_LO 8'he0
`define IFC_OPC_SKIP_HI 8'he7
`define IFC_OPC_COND_LO 8'h30
`define IFC_OPC_COND_HI 8'h3e
`define IFC_OPC_LIT_LO 8'h40
`define IFC_OPC_LIT_HI 8'h7f
`define IFC_OPC_FILE_LO 8'hb0
`define IFC_OPC_FILE_HI 8'hb9
`define IFC_OPC_BIT_LO 8'ha0
`define IFC_OPC_BIT_HI 8'haf
`define IFC_OPC_WORK_LO 8'h80
`define IFC_OPC_WORK_HI 8'h9f
`define IFC_DEST_FILE_BIT 13
`define IFC_BITSEL_IND_BIT 11
`define IFC_LIT_SAME_BIT 15
`define IFC_CYC_LONG 2'h3
`define IFC_CYC_ONE 2'h1
`define IFC_CYC_TWO 2'h2
`define IFC_BASE_MSB 14
`define IFC_BASE_LSB 11
`define IFC_SRC_MSB 6
`define IFC_SRC_LSB 0
`define IFC_DST_MSB 13
`define IFC_DST_LSB 7
`define IFC_FADDR_MSB 12
`define IFC_FADDR_LSB 0
`define IFC_BITSEL_MSB 15
`define IFC_BITSEL_LSB 12
`define IFC_LIT_MSB 13
`define IFC_LIT_LSB 4
`endif

/* include/ifc_pkg.sv */
package ifc_pkg;
	typedef enum logic [2:0] {
		IFC_CAT_NOP = 3'h0,
		IFC_CAT_WORK = 3'h1,
		IFC_CAT_FILE = 3'h2,
		IFC_CAT_BIT = 3'h3,
		IFC_CAT_LIT = 3'h4,
		IFC_CAT_CTRL = 3'h5
	} ifc_cat_t;
	typedef struct packed {
		ifc_cat_t cat;
		logic [7:0] opcode;
		logic [3:0] base_reg;
		logic [6:0] src_reg;
		logic [6:0] dst_reg;
		logic [12:0] file_addr;
		logic dest_is_file;
		logic bit_indirect;
		logic [3:0] bit_sel;
		logic [9:0] literal;
		logic two_word;
		logic flow;
		logic skip;
		logic cond;
		logic long_op;
	} ifc_dec_t;
	typedef enum logic [1:0] {
		IFC_ST_FIRST = 2'b00,
		IFC_ST_SECOND = 2'b01,
		IFC_ST_FILL = 2'b10
	} ifc_state_t;
endpackage

/* rtl/ifc_field_decode.sv */
`timescale 1ns/100ps
`include "ifc_regs.svh"
module ifc_field_decode (
	input wire logic [23:0] i_word,
	output ifc_pkg::ifc_dec_t o_dec
);
	logic [7:0] opc;
	assign opc = i_word[`IFC_OPC_MSB:`IFC_OPC_LSB];
	always_comb begin
		o_dec = '0;
		o_dec.opcode = opc;
		o_dec.base_reg = i_word[`IFC_BASE_MSB:`IFC_BASE_LSB];
		o_dec.src_reg = i_word[`IFC_SRC_MSB:`IFC_SRC_LSB];
		o_dec.dst_reg = i_word[`IFC_DST_MSB:`IFC_DST_LSB];
		o_dec.file_addr = i_word[`IFC_FADDR_MSB:`IFC_FADDR_LSB];
		o_dec.bit_sel = i_word[`IFC_BITSEL_MSB:`IFC_BITSEL_LSB];
		o_dec.literal = i_word[`IFC_LIT_MSB:`IFC_LIT_LSB];
		o_dec.two_word = (opc == `IFC_OPC_DW0) || (opc == `IFC_OPC_DW1) ||
			(opc == `IFC_OPC_DW2);
		o_dec.cat = ifc_pkg::IFC_CAT_CTRL;
		if (opc == `IFC_OPC_NOP) begin
			o_dec.cat = ifc_pkg::IFC_CAT_NOP;
		end else if (opc >= `IFC_OPC_WORK_LO && opc <= `IFC_OPC_WORK_HI) begin
			o_dec.cat = ifc_pkg::IFC_CAT_WORK;
		end else if (opc >= `IFC_OPC_FILE_LO && opc <= `IFC_OPC_FILE_HI) begin
			o_dec.cat = ifc_pkg::IFC_CAT_FILE;
			o_dec.dest_is_file = i_word[`IFC_DEST_FILE_BIT];
			// Register-side result always lands in the first working register
			o_dec.dst_reg = 7'h00;
		end else if (opc >= `IFC_OPC_BIT_LO && opc <= `IFC_OPC_BIT_HI) begin
			o_dec.cat = ifc_pkg::IFC_CAT_BIT;
			o_dec.bit_indirect = i_word[`IFC_BITSEL_IND_BIT];
		end else if (opc >= `IFC_OPC_LIT_LO && opc <= `IFC_OPC_LIT_HI) begin
			o_dec.cat = ifc_pkg::IFC_CAT_LIT;
			// Destination defaults to the base register when flagged as same
			if (i_word[`IFC_LIT_SAME_BIT]) begin
				o_dec.dst_reg = {3'h0, i_word[`IFC_BASE_MSB:`IFC_BASE_LSB]};
			end
		end
		o_dec.flow = (opc == `IFC_OPC_BRANCH) || (opc == `IFC_OPC_CALL_IND) ||
			(opc == `IFC_OPC_RET) || o_dec.two_word;
		o_dec.long_op = (opc == `IFC_OPC_BRANCH) || (opc == `IFC_OPC_CALL_IND) ||
			(opc == `IFC_OPC_TBL_LO) || (opc == `IFC_OPC_TBL_HI) ||
			(opc == `IFC_OPC_RET);
		o_dec.skip = opc >= `IFC_OPC_SKIP_LO && opc <= `IFC_OPC_SKIP_HI;
		o_dec.cond = opc >= `IFC_OPC_COND_LO && opc <= `IFC_OPC_COND_HI;
	end
endmodule // ifc_field_decode

/* rtl/ifc_cycle_ctrl.sv */
`timescale 1ns/100ps
`include "ifc_regs.svh"
// Contract
// - Single word is 24 bits with an 8-bit opcode and operand fields.
// - Most instructions take one word; three opcodes take two words.
// - Two-word instruction spans 48 bits; second word upper byte zero.
// - A lone second word executes as a no-operation.
// - Working-register ops take base, source and destination operands.
// - File ops write back to the file register or first working register.
// - Bit ops pick the bit by literal or by base register contents.
// - Literal ops use base and literal; destination only when different.
// - One cycle; two when a condition is true or flow changes.
// - Branch, indirect call, table ops, returns take two or three cycles.
// - Taken skip lasts two cycles, three over a two-word instruction.
// - Double-word moves and all two-word instructions take two cycles.
module ifc_cycle_ctrl (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_word_vld,
	input wire logic [23:0] i_word,
	input wire logic i_cond_true,
	input wire logic i_long_three,
	input wire logic i_next_two_word,
	output ifc_pkg::ifc_dec_t o_dec,
	output logic o_dec_vld,
	output logic o_exec_nop,
	output logic o_fetch_rdy,
	output logic [47:0] o_dword,
	output logic o_dword_err,
	output logic [1:0] o_cycles
);
	ifc_pkg::ifc_dec_t dec;
	ifc_pkg::ifc_dec_t hold_q;
	ifc_pkg::ifc_state_t state_q;
	logic [23:0] first_q;
	logic [1:0] fill_q;
	logic [1:0] need;
	logic [1:0] cyc_q;

	ifc_field_decode u_dec (
		.i_word(i_word),
		.o_dec(dec)
	);

	// Cycle budget of the first word, derived once so both counter and report agree
	always_comb begin
		need = `IFC_CYC_ONE;
		if (dec.two_word) begin
			need = `IFC_CYC_TWO;
		end else if (dec.long_op) begin
			need = i_long_three ? `IFC_CYC_LONG : `IFC_CYC_TWO;
		end else if (dec.skip && i_cond_true) begin
			need = i_next_two_word ? `IFC_CYC_LONG : `IFC_CYC_TWO;
		end else if (dec.flow || (dec.cond && i_cond_true)) begin
			need = `IFC_CYC_TWO;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_q <= ifc_pkg::IFC_ST_FIRST;
			fill_q <= 2'h0;
			cyc_q <= 2'h0;
		end else begin
			unique case (state_q)
				ifc_pkg::IFC_ST_FIRST: begin
					if (i_word_vld) begin
						cyc_q <= need;
						if (dec.two_word) begin
							state_q <= ifc_pkg::IFC_ST_SECOND;
						end else if (need > 2'h1) begin
							fill_q <= need - 2'h1;
							state_q <= ifc_pkg::IFC_ST_FILL;
						end
					end
				end
				ifc_pkg::IFC_ST_SECOND: begin
					if (i_word_vld) begin
						state_q <= ifc_pkg::IFC_ST_FIRST;
					end
				end
				ifc_pkg::IFC_ST_FILL: begin
					fill_q <= fill_q - 2'h1;
					if (fill_q == 2'h1) begin
						state_q <= ifc_pkg::IFC_ST_FIRST;
					end
				end
				default: begin
					state_q <= ifc_pkg::IFC_ST_FIRST;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			first_q <= 24'h000000;
			hold_q <= '0;
		end else if (state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld) begin
			first_q <= i_word;
			hold_q <= dec;
		end
	end

	// Outputs are registered; the fill cycles present a nop to the datapath
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_dec <= '0;
			o_dec_vld <= 1'b0;
			o_exec_nop <= 1'b0;
			o_fetch_rdy <= 1'b0;
			o_dword <= 48'h000000000000;
			o_dword_err <= 1'b0;
			o_cycles <= 2'h0;
		end else begin
			o_dec_vld <= 1'b0;
			o_exec_nop <= 1'b0;
			o_dword_err <= 1'b0;
			o_fetch_rdy <= (state_q != ifc_pkg::IFC_ST_FILL) || (fill_q == 2'h1);
			unique case (state_q)
				ifc_pkg::IFC_ST_FIRST: begin
					if (i_word_vld && !dec.two_word) begin
						o_dec <= dec;
						o_dec_vld <= 1'b1;
						o_cycles <= need;
						// Stray second word decodes as nop
						o_exec_nop <= (dec.cat == ifc_pkg::IFC_CAT_NOP);
						o_fetch_rdy <= (need == 2'h1);
					end
				end
				ifc_pkg::IFC_ST_SECOND: begin
					if (i_word_vld) begin
						o_dec <= hold_q;
						o_dec_vld <= 1'b1;
						o_cycles <= cyc_q;
						o_dword <= {first_q, i_word};
						o_dword_err <= (i_word[`IFC_OPC_MSB:`IFC_OPC_LSB] != `IFC_OPC_NOP);
					end
				end
				ifc_pkg::IFC_ST_FILL: begin
					o_exec_nop <= 1'b1;
				end
				default: begin
					o_exec_nop <= 1'b0;
				end
			endcase
		end
	end

	// Zero upper byte: lone second words and true nops both retire as a bubble
	chk_nop_zero_opc: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && i_word[23:16] == 8'h00)
		|=> o_exec_nop && o_dec_vld) else $error("zero opcode not a nop");

	chk_two_word_cycles: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_SECOND && i_word_vld) |=> o_cycles == 2'h2)
		else $error("two-word cycles wrong");

	chk_two_word_seq: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.two_word)
		|=> state_q == ifc_pkg::IFC_ST_SECOND) else $error("second word missed");

	// The first word of a pair is only held; announcing it early would execute half an op
	chk_pair_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.two_word)
		|=> !o_dec_vld && o_fetch_rdy) else $error("first word of pair announced");

	chk_dword_upper: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_SECOND && i_word_vld && i_word[23:16] == 8'h00)
		|=> !o_dword_err && o_dword[23:0] == $past(i_word)) else $error("dword bad");

	chk_dword_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_SECOND && i_word_vld && i_word[23:16] != 8'h00)
		|=> o_dword_err) else $error("nonzero second word not flagged");

	chk_single_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && need == 2'h1)
		|=> state_q == ifc_pkg::IFC_ST_FIRST && o_fetch_rdy) else $error("single cycle stalled");

	chk_cond_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.cond && i_cond_true
		&& !dec.long_op && !dec.skip && !dec.two_word)
		|=> (o_cycles == 2'h2 && !o_fetch_rdy) ##1 (o_exec_nop && o_fetch_rdy))
		else $error("true condition not two cycles");

	chk_fill_refuse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		state_q == ifc_pkg::IFC_ST_FILL |=> !o_dec_vld && o_exec_nop)
		else $error("fill cycle not a bubble");

	chk_skip_three: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.skip && i_cond_true
		&& i_next_two_word) |=> o_cycles == 2'h3 ##1 o_exec_nop ##1 o_exec_nop)
		else $error("skip over two words");

	chk_skip_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.skip && i_cond_true
		&& !i_next_two_word) |=> o_cycles == 2'h2 ##1 (o_exec_nop && o_fetch_rdy))
		else $error("skip over one word");

	chk_skip_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.skip && !i_cond_true)
		|=> o_cycles == 2'h1 && o_fetch_rdy) else $error("untaken skip stalled");

	chk_long_min: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.long_op && !dec.two_word)
		|=> o_cycles >= 2'h2 ##1 o_exec_nop) else $error("long op too short");

	chk_long_three: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.long_op && i_long_three)
		|=> (o_cycles == 2'h3 && !o_fetch_rdy) ##1 (o_exec_nop && !o_fetch_rdy)
		##1 (o_exec_nop && o_fetch_rdy)) else $error("three-cycle long op wrong");

	chk_long_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && dec.long_op && !i_long_three)
		|=> o_cycles == 2'h2 ##1 (o_exec_nop && o_fetch_rdy))
		else $error("two-cycle long op wrong");

	chk_opcode_field: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_dec_vld |-> (o_dec.opcode == $past(i_word[23:16])) ||
		($past(state_q) == ifc_pkg::IFC_ST_SECOND)) else $error("opcode field wrong");

	chk_work_cat: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_q == ifc_pkg::IFC_ST_FIRST && i_word_vld && i_word[23:16] >= `IFC_OPC_WORK_LO
		&& i_word[23:16] <= `IFC_OPC_WORK_HI) |=> o_dec.cat == ifc_pkg::IFC_CAT_WORK)
		else $error("working register op miscategorised");

	chk_file_dest: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_dec_vld && o_dec.cat == ifc_pkg::IFC_CAT_FILE && !o_dec.dest_is_file
		|-> o_dec.dst_reg == 7'h00) else $error("file result not to first register");

	chk_lit_dest: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_dec_vld && o_dec.cat == ifc_pkg::IFC_CAT_LIT && $past(i_word[15])
		&& $past(state_q) == ifc_pkg::IFC_ST_FIRST |-> o_dec.dst_reg[3:0] == o_dec.base_reg)
		else $error("literal dest");
endmodule // ifc_cycle_ctrl

/* tb/ifc_prog_mem_model.sv */
`timescale 1ns/100ps
module ifc_prog_mem_model (
	input wire logic i_clk_sys,
	input wire logic i_fetch,
	input wire logic [23:0] i_word_in,
	output logic o_word_vld,
	output logic [23:0] o_word
);
	logic [23:0] last_q = 24'h5a5a5a;
	// Idle bus flips every cycle so a stale word is never taken for a fresh one
	always @(posedge i_clk_sys) begin
		last_q <= i_fetch ? i_word_in : ~last_q;
	end
	assign o_word_vld = i_fetch;
	assign o_word = i_fetch ? i_word_in : ~last_q;
endmodule // ifc_prog_mem_model

/* tb/instruction_format_cycle_control_tb.sv */
`timescale 1ns/100ps
module instruction_format_cycle_control_tb;
	typedef struct packed {
		logic [23:0] w1;
		logic [23:0] w2;
		logic [3:0] f;
		ifc_pkg::ifc_cat_t cat;
		logic [1:0] cyc;
	} ifc_row_t;
	// Flags: two-word, condition true, three-cycle long op, skipped op is two-word
	ifc_row_t rows [18] = '{
		'{24'h000000, 24'h0, 4'h0, ifc_pkg::IFC_CAT_NOP, 2'h1},
		'{24'h801234, 24'h0, 4'h0, ifc_pkg::IFC_CAT_WORK, 2'h1},
		'{24'hb02000, 24'h0, 4'h0, ifc_pkg::IFC_CAT_FILE, 2'h1},
		'{24'ha00800, 24'h0, 4'h0, ifc_pkg::IFC_CAT_BIT, 2'h1},
		'{24'h408ab0, 24'h0, 4'h0, ifc_pkg::IFC_CAT_LIT, 2'h1},
		'{24'hb10000, 24'h0, 4'h0, ifc_pkg::IFC_CAT_FILE, 2'h1},
		'{24'h300010, 24'h0, 4'h4, ifc_pkg::IFC_CAT_CTRL, 2'h2},
		'{24'h300010, 24'h0, 4'h0, ifc_pkg::IFC_CAT_CTRL, 2'h1},
		'{24'h370000, 24'h0, 4'h0, ifc_pkg::IFC_CAT_CTRL, 2'h2},
		'{24'h370000, 24'h0, 4'h2, ifc_pkg::IFC_CAT_CTRL, 2'h3},
		'{24'hbb0000, 24'h0, 4'h0, ifc_pkg::IFC_CAT_CTRL, 2'h2},
		'{24'h060000, 24'h0, 4'h2, ifc_pkg::IFC_CAT_CTRL, 2'h3},
		'{24'he00000, 24'h0, 4'h4, ifc_pkg::IFC_CAT_CTRL, 2'h2},
		'{24'he00000, 24'h0, 4'h5, ifc_pkg::IFC_CAT_CTRL, 2'h3},
		'{24'he00000, 24'h0, 4'h0, ifc_pkg::IFC_CAT_CTRL, 2'h1},
		'{24'h020000, 24'h000123, 4'h8, ifc_pkg::IFC_CAT_CTRL, 2'h2},
		'{24'h040000, 24'h00abcd, 4'h8, ifc_pkg::IFC_CAT_CTRL, 2'h2},
		'{24'hbe0000, 24'h000001, 4'h8, ifc_pkg::IFC_CAT_CTRL, 2'h2}
	};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic fetch = 1'b0;
	logic cond = 1'b0;
	logic l3 = 1'b0;
	logic n2 = 1'b0;
	logic [23:0] word_in = 24'h000000;
	logic word_vld;
	logic [23:0] word;
	ifc_pkg::ifc_dec_t dec;
	logic dec_vld, exec_nop, fetch_rdy, dword_err;
	logic [47:0] dword;
	logic [1:0] cycles;
	logic [17:0] ops;
	assign ops = {dec.base_reg, dec.src_reg, dec.dst_reg};
	int failures = 0;
	int samples_checked = 0;
	int nops = 0;
	always #2.5 clk = ~clk;
	ifc_prog_mem_model mem (.i_clk_sys(clk), .i_fetch(fetch), .i_word_in(word_in),
		.o_word_vld(word_vld), .o_word(word));
	ifc_cycle_ctrl dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_word_vld(word_vld), .i_word(word),
		.i_cond_true(cond), .i_long_three(l3), .i_next_two_word(n2), .o_dec(dec),
		.o_dec_vld(dec_vld), .o_exec_nop(exec_nop), .o_fetch_rdy(fetch_rdy), .o_dword(dword),
		.o_dword_err(dword_err), .o_cycles(cycles));
	task automatic wrap_up();
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	// Waits out fill cycles, counting the no-operation pulses, then one spare cycle
	task automatic settle();
		int n;
		n = 0;
		nops = 0;
		while (fetch_rdy !== 1'b1 && n < 8) begin
			step();
			n++;
			nops += (exec_nop === 1'b1);
		end
		if (n == 8) begin
			failures++;
			wrap_up();
		end
		step();
	endtask
	task automatic issue(input ifc_row_t r);
		fetch = 1'b1;
		word_in = r.w1;
		{cond, l3, n2} = r.f[2:0];
		step();
		if (r.f[3]) begin
			word_in = r.w2;
			step();
		end
		fetch = 1'b0;
		chk("dec_vld", 48'h1, {47'h0, dec_vld});
		chk("opcode", {40'h0, r.w1[23:16]}, {40'h0, dec.opcode});
		chk("cycles", {46'h0, r.cyc}, {46'h0, cycles});
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1;
		chk("reset cycles", 48'h0, {46'h0, cycles});
		rst_n = 1'b1;
		step();
		step();
		for (int i = 0; i < 18; i++) begin
			issue(rows[i]);
			if (i < 6) chk("cat", {45'h0, rows[i].cat}, {45'h0, dec.cat});
			if (i == 0) chk("nop", 48'h1, {47'h0, exec_nop});
			if (i == 2 || i == 5) chk("dest", {47'h0, rows[i].w1[13]}, {47'h0, dec.dest_is_file});
			if (i == 5) chk("dst", 48'h0, {41'h0, dec.dst_reg});
			if (i == 3) chk("bit_ind", 48'h1, {47'h0, dec.bit_indirect});
			if (i == 1) chk("operands", {30'h0, 4'h2, 7'h34, 7'h24}, {30'h0, ops});
			if (i == 4) chk("lit dst", {31'h0, 10'h0ab, 7'h01}, {31'h0, dec.literal, dec.dst_reg});
			if (rows[i].f[3]) chk("dword", {rows[i].w1, rows[i].w2}, dword);
			if (rows[i].f[3]) chk("dword_err", 48'h0, {47'h0, dword_err});
			settle();
			if (!rows[i].f[3]) chk("fill", {46'h0, rows[i].cyc - 2'h1}, 48'(nops));
		end
		issue('{24'h020000, 24'h150000, 4'h8, ifc_pkg::IFC_CAT_CTRL, 2'h2});
		chk("bad second", 48'h1, {47'h0, dword_err});
		settle();
		// A word offered during fill must not decode
		fetch = 1'b1;
		word_in = 24'h370000;
		l3 = 1'b1;
		step();
		word_in = 24'h408000;
		step();
		fetch = 1'b0;
		chk("fill refuse", 48'h0, {47'h0, dec_vld});
		chk("fill nop", 48'h1, {47'h0, exec_nop});
		settle();
		issue(rows[9]);
		rst_n = 1'b0;
		step();
		chk("rst", 48'h0, {44'h0, dec_vld, fetch_rdy, cycles});
		chk("rst dword", 48'h0, dword);
		rst_n = 1'b1;
		step();
		issue(rows[1]);
		settle();
		wrap_up();
	end
endmodule // instruction_format_cycle_control_tb
